// [srs_dev.sv]
// slave end of the two-wire register port
//
// Contract
// - slave only; reference clock times serial logic, link lines are sampled
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - address 1010101 strap low, 0110011 high
// - strap sampled once after reset, then fixed
// - ack holds sda low through scl high
// - master changes sda only while scl low
// - eight bits, msb first, then ack slot
// - write: address, register, data, each acked
// - write ends on stop or new start
// - read begins with address and register acked
// - repeated start, read address, ack, data out
// - read ends on nack then stop/start
`timescale 1ns/100ps
`include "srs_regs.svh"
module srs_dev
    import srs_pkg::*;
#(
    parameter int unsigned STRAP_CYC = `SRS_STRAP_CYC
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_srst,
    // two-wire link
    srs_if.dev              bus,
    // address select strap
    input  wire logic       i_addr_sel,
    // register file side
    input  wire logic [7:0] i_rd_data,
    output logic      [7:0] o_rd_addr,
    output logic            o_wr_stb,
    output logic      [7:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    // status
    output logic      [6:0] o_own_addr,
    output logic            o_busy
);

    logic [1:0]  scl_ff_r;
    logic [1:0]  sda_ff_r;
    logic        scl_q_r;
    logic        sda_q_r;
    logic [1:0]  strap_ff_r;
    logic [3:0]  strap_cnt_r;
    logic        strap_done_r;
    logic [6:0]  own_addr_r;
    srs_dev_st_e st_r;
    srs_phase_e  phase_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  rx_sh_r;
    logic [7:0]  tx_sh_r;
    logic        rd_r;
    logic        mack_r;
    logic [7:0]  reg_addr_r;
    logic        wr_stb_r;
    logic [7:0]  wr_addr_r;
    logic [7:0]  wr_data_r;
    logic        sda_oe_n_r;
    logic        busy_r;
    logic        scl_s;
    logic        sda_s;
    logic        start_det;
    logic        stop_det;
    logic        scl_rise;
    logic        scl_fall;
    logic        byte_done;
    logic        addr_hit;

    function automatic srs_phase_e next_phase(input srs_phase_e ph);
        case (ph)
            PH_DEV:  next_phase = PH_REG;
            PH_REG:  next_phase = PH_DATA;
            default: next_phase = PH_MORE;
        endcase
    endfunction

    // link lines cross in through two flops; a third stage feeds edge detection
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            scl_ff_r <= 2'h3;
            sda_ff_r <= 2'h3;
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
        end else begin
            scl_ff_r <= {scl_ff_r[0], bus.scl};
            sda_ff_r <= {sda_ff_r[0], bus.sda};
            scl_q_r  <= scl_ff_r[1];
            sda_q_r  <= sda_ff_r[1];
        end
    end

    assign scl_s     = scl_ff_r[1];
    assign sda_s     = sda_ff_r[1];
    // sda may only move while scl is low, so any move with scl high is a condition
    assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;
    assign byte_done = scl_fall & (bit_cnt_r == `SRS_BYTE_BITS);
    assign addr_hit  = (rx_sh_r[7:1] == own_addr_r);

    // strap is caught once after reset release and then held
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            strap_ff_r   <= 2'h0;
            strap_cnt_r  <= 4'h0;
            strap_done_r <= 1'b0;
            own_addr_r   <= `SRS_ADDR_SEL_LO;
        end else begin
            strap_ff_r <= {strap_ff_r[0], i_addr_sel};
            if (!strap_done_r) begin
                // wait out both synchroniser stages before trusting the strap
                if (strap_cnt_r == 4'(STRAP_CYC + 2)) begin
                    strap_done_r <= 1'b1;
                    own_addr_r   <= strap_ff_r[1] ? `SRS_ADDR_SEL_HI
                                                  : `SRS_ADDR_SEL_LO;
                end else begin
                    strap_cnt_r <= strap_cnt_r + 4'h1;
                end
            end
        end
    end

    // transfer sequencing; stop and start override every state
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_r       <= DS_IDLE;
            phase_r    <= PH_DEV;
            bit_cnt_r  <= 4'h0;
            rx_sh_r    <= `SRS_RST_BYTE;
            tx_sh_r    <= `SRS_RST_BYTE;
            rd_r       <= 1'b0;
            mack_r     <= 1'b0;
            reg_addr_r <= `SRS_RST_REG_ADDR;
        end else if (stop_det) begin
            st_r <= DS_IDLE;
        end else if (start_det) begin
            st_r      <= DS_RX;
            phase_r   <= PH_DEV;
            bit_cnt_r <= 4'h0;
        end else begin
            case (st_r)
                DS_IDLE: begin
                    bit_cnt_r <= 4'h0;
                end
                DS_RX: begin
                    if (scl_rise && bit_cnt_r != `SRS_BYTE_BITS) begin
                        rx_sh_r   <= {rx_sh_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        case (phase_r)
                            PH_DEV: begin
                                if (addr_hit && strap_done_r) begin
                                    st_r <= DS_ACK;
                                    rd_r <= rx_sh_r[0];
                                end else begin
                                    st_r <= DS_IGNORE;
                                end
                            end
                            PH_REG: begin
                                st_r       <= DS_ACK;
                                reg_addr_r <= rx_sh_r;
                            end
                            PH_DATA: begin
                                st_r <= DS_ACK;
                            end
                            default: begin
                                // only one data byte per write; extra bytes get no ack
                                st_r <= DS_IGNORE;
                            end
                        endcase
                    end
                end
                DS_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (phase_r == PH_DEV && rd_r) begin
                            st_r    <= DS_TX;
                            tx_sh_r <= i_rd_data;
                        end else begin
                            st_r    <= DS_RX;
                            phase_r <= next_phase(phase_r);
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == `SRS_BYTE_BITS - 4'h1) begin
                            st_r <= DS_MACK;
                        end else begin
                            tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                DS_MACK: begin
                    if (scl_rise) begin
                        mack_r <= ~sda_s;
                        if (!sda_s) begin
                            reg_addr_r <= reg_addr_r + 8'h01;
                        end
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r) begin
                            st_r    <= DS_TX;
                            tx_sh_r <= i_rd_data;
                        end else begin
                            st_r <= DS_IGNORE;
                        end
                    end
                end
                DS_IGNORE: begin
                    bit_cnt_r <= 4'h0;
                end
                default: begin
                    st_r <= DS_IDLE;
                end
            endcase
        end
    end

    // register write strobe, one cycle, issued as the data byte completes
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wr_stb_r  <= 1'b0;
            wr_addr_r <= `SRS_RST_REG_ADDR;
            wr_data_r <= `SRS_RST_BYTE;
        end else begin
            wr_stb_r <= 1'b0;
            if (!stop_det && !start_det && st_r == DS_RX && byte_done
                && phase_r == PH_DATA) begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= reg_addr_r;
                wr_data_r <= rx_sh_r;
            end
        end
    end

    // sda is open drain: pulled low for ack and zero read bits, else released;
    // it follows the state one cycle late, well inside the scl low phase
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sda_oe_n_r <= 1'b1;
        end else begin
            sda_oe_n_r <= ~((st_r == DS_ACK)
                            | ((st_r == DS_TX) & ~tx_sh_r[7]));
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (st_r != DS_IDLE) && (st_r != DS_IGNORE);
        end
    end

    assign bus.dev_sda_o    = 1'b0;
    assign bus.dev_sda_oe_n = sda_oe_n_r;
    assign o_rd_addr        = reg_addr_r;
    assign o_wr_stb         = wr_stb_r;
    assign o_wr_addr        = wr_addr_r;
    assign o_wr_data        = wr_data_r;
    assign o_own_addr       = own_addr_r;
    assign o_busy           = busy_r;

endmodule // srs_dev

// [srs_regs.svh]
// timing counts, bus addresses and reset values of the two-wire register slave
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// own address with the select strap low and high
`define SRS_ADDR_SEL_LO    7'h55
`define SRS_ADDR_SEL_HI    7'h33

// bits in one byte, and the acknowledge slot that follows them
`define SRS_BYTE_BITS      4'h8

// reference clock period and serial clock period, in ns
`define SRS_REF_PERIOD_NS  25
`define SRS_SCL_PERIOD_NS  2500

// quarter of a serial clock period in reference cycles, rounded down
`define SRS_SCL_QTR_CYC    ((`SRS_SCL_PERIOD_NS / 4) / `SRS_REF_PERIOD_NS)

// reference cycles after reset release, on top of the two synchroniser stages, before the strap is taken
`define SRS_STRAP_CYC      3

// reset values
`define SRS_RST_BYTE       8'h00
`define SRS_RST_REG_ADDR   8'h00

`endif

// [srs_pkg.sv]
// types shared by both ends of the two-wire register link
package srs_pkg;

    typedef enum logic [2:0] {
        DS_IDLE,
        DS_RX,
        DS_ACK,
        DS_TX,
        DS_MACK,
        DS_IGNORE
    } srs_dev_st_e;

    typedef enum logic [1:0] {
        PH_DEV,
        PH_REG,
        PH_DATA,
        PH_MORE
    } srs_phase_e;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_START,
        HS_BIT,
        HS_STOP
    } srs_host_st_e;

endpackage

// [srs_if.sv]
// two-wire bus between host master and register slave, with pull-up resolution
`timescale 1ns/100ps
interface srs_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // a released line floats high through the pull-up
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport host (
        output host_scl_o,
        output host_scl_oe_n,
        output host_sda_o,
        output host_sda_oe_n,
        input  scl,
        input  sda
    );

    modport dev (
        output dev_sda_o,
        output dev_sda_oe_n,
        input  scl,
        input  sda
    );
endinterface

// [srs_host.sv]
// master end of the two-wire register port: one write or one read per request
`timescale 1ns/100ps
`include "srs_regs.svh"
module srs_host
    import srs_pkg::*;
#(
    parameter int unsigned QTR_CYC = `SRS_SCL_QTR_CYC
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_srst,
    // two-wire link
    srs_if.host             bus,
    // request
    input  wire logic       i_go,
    input  wire logic       i_rw,
    input  wire logic [6:0] i_dev_addr,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_wr_data,
    // answer
    output logic            o_busy,
    output logic            o_done,
    output logic            o_ack_err,
    output logic      [7:0] o_rd_data
);

    logic [15:0]  qcnt_r;
    logic         tick_r;
    logic [1:0]   sda_ff_r;
    srs_host_st_e st_r;
    logic [1:0]   ph_r;
    logic [1:0]   bidx_r;
    logic [3:0]   bit_r;
    logic [7:0]   sh_r;
    logic [7:0]   rd_sh_r;
    logic         rw_r;
    logic [6:0]   dev_r;
    logic [7:0]   reg_r;
    logic [7:0]   dat_r;
    logic         scl_r;
    logic         sda_r;
    logic         err_r;
    logic         busy_r;
    logic         done_r;
    logic [7:0]   rd_data_r;
    logic         last_byte;

    // byte sent in each slot; slot 3 is the read byte, sent as all released
    function automatic logic [7:0] byte_of(input logic [1:0] idx, input logic rw,
                                           input logic [6:0] dev, input logic [7:0] rg,
                                           input logic [7:0] dat);
        case (idx)
            2'h0:    byte_of = {dev, 1'b0};
            2'h1:    byte_of = rg;
            2'h2:    byte_of = rw ? {dev, 1'b1} : dat;
            default: byte_of = 8'hff;
        endcase
    endfunction

    assign last_byte = rw_r ? (bidx_r == 2'h3) : (bidx_r == 2'h2);

    // quarter-period enable; scl is built from four of them per bit
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            qcnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (qcnt_r == 16'(QTR_CYC - 1));
            qcnt_r <= (qcnt_r == 16'(QTR_CYC - 1)) ? 16'h0000 : qcnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sda_ff_r <= 2'h3;
        end else begin
            sda_ff_r <= {sda_ff_r[0], bus.sda};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_r      <= HS_IDLE;
            ph_r      <= 2'h0;
            bidx_r    <= 2'h0;
            bit_r     <= 4'h0;
            sh_r      <= 8'h00;
            rd_sh_r   <= 8'h00;
            rw_r      <= 1'b0;
            dev_r     <= 7'h00;
            reg_r     <= 8'h00;
            dat_r     <= 8'h00;
            scl_r     <= 1'b1;
            sda_r     <= 1'b1;
            err_r     <= 1'b0;
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            case (st_r)
                HS_IDLE: begin
                    if (i_go) begin
                        st_r   <= HS_START;
                        ph_r   <= 2'h0;
                        bidx_r <= 2'h0;
                        rw_r   <= i_rw;
                        dev_r  <= i_dev_addr;
                        reg_r  <= i_reg_addr;
                        dat_r  <= i_wr_data;
                        err_r  <= 1'b0;
                        busy_r <= 1'b1;
                    end
                end
                HS_START: begin
                    if (tick_r) begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0:    sda_r <= 1'b1;
                            2'h1:    scl_r <= 1'b1;
                            2'h2:    sda_r <= 1'b0;
                            default: begin
                                scl_r <= 1'b0;
                                st_r  <= HS_BIT;
                                bit_r <= 4'h0;
                                sh_r  <= byte_of(bidx_r, rw_r, dev_r, reg_r, dat_r);
                            end
                        endcase
                    end
                end
                HS_BIT: begin
                    if (tick_r) begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0: begin
                                // data moves only with scl low; ack slots are released
                                sda_r <= (bit_r == `SRS_BYTE_BITS) | (bidx_r == 2'h3)
                                         | sh_r[7];
                            end
                            2'h1:    scl_r <= 1'b1;
                            2'h2: begin
                                if (bit_r != `SRS_BYTE_BITS) begin
                                    rd_sh_r <= {rd_sh_r[6:0], sda_ff_r[1]};
                                end else if (bidx_r != 2'h3 && sda_ff_r[1]) begin
                                    err_r <= 1'b1;
                                end
                            end
                            default: begin
                                scl_r <= 1'b0;
                                if (bit_r == `SRS_BYTE_BITS) begin
                                    bit_r <= 4'h0;
                                    if (err_r || last_byte) begin
                                        st_r <= HS_STOP;
                                    end else if (rw_r && bidx_r == 2'h1) begin
                                        st_r   <= HS_START;
                                        bidx_r <= 2'h2;
                                    end else begin
                                        bidx_r <= bidx_r + 2'h1;
                                        sh_r   <= byte_of(bidx_r + 2'h1, rw_r, dev_r,
                                                          reg_r, dat_r);
                                    end
                                end else begin
                                    bit_r <= bit_r + 4'h1;
                                    sh_r  <= {sh_r[6:0], 1'b0};
                                end
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (tick_r) begin
                        ph_r <= ph_r + 2'h1;
                        case (ph_r)
                            2'h0:    sda_r <= 1'b0;
                            2'h1:    scl_r <= 1'b1;
                            2'h2:    sda_r <= 1'b1;
                            default: begin
                                st_r      <= HS_IDLE;
                                busy_r    <= 1'b0;
                                done_r    <= 1'b1;
                                rd_data_r <= rd_sh_r;
                            end
                        endcase
                    end
                end
                default: begin
                    st_r <= HS_IDLE;
                end
            endcase
        end
    end

    // both lines open drain: a one is a release
    assign bus.host_scl_o    = 1'b0;
    assign bus.host_scl_oe_n = scl_r;
    assign bus.host_sda_o    = 1'b0;
    assign bus.host_sda_oe_n = sda_r;
    assign o_busy            = busy_r;
    assign o_done            = done_r;
    assign o_ack_err         = err_r;
    assign o_rd_data         = rd_data_r;

endmodule // srs_host

// [srs_properties.sv]
// concurrent checks on the two-wire link between host and slave ends
`timescale 1ns/100ps
module srs_properties (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // link drivers and resolved levels
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence

    low_only_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("a driver puts a high level on the wire");
    dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("slave changed its data drive while the clock was high");
    ack_hold_a: assert property ($rose(scl) && !dev_sda_oe_n |=> !dev_sda_oe_n [*8])
        else $error("slave let go of the data line inside a clock high phase");
    start_quiet_a: assert property (s_start |-> dev_sda_oe_n [*8])
        else $error("slave drove the data line right after a start");
    stop_idle_a: assert property (s_stop |=> scl [*8])
        else $error("clock pulled low right after a stop");
    start_clk_a: assert property (s_start |-> ##[1:60] !scl)
        else $error("no clock low phase after a start");
    bit_stable_a: assert property ($rose(scl) |=> $stable(sda) [*8])
        else $error("data line moved early in a clock high phase");
    // long zero runs of read data keep the drive on, hence the wide bound
    drive_bound_a: assert property ($fell(dev_sda_oe_n) |-> ##[1:1000] dev_sda_oe_n)
        else $error("slave never released the data line");
endmodule // srs_properties

// [tb_serial_register_slave.sv]
// self-checking bench: host and slave ends joined over the two-wire link
`timescale 1ns/100ps
module tb_serial_register_slave;
    logic       clk;
    logic       srst;
    logic       sel;
    logic       go;
    logic       rw;
    logic [6:0] dev;
    logic [7:0] rg;
    logic [7:0] wd;
    logic [7:0] rd_addr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] h_rd;
    logic [6:0] own;
    logic       wr_stb;
    logic       done;
    logic       ack_err;
    logic       drove;
    logic       d_busy;
    logic       h_busy;
    logic       busy_seen;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shf;
    logic [7:0] first_byte;
    logic [7:0] mem [256];
    int         bit_n;
    int         stb_n;
    int         cycles;
    int         mismatches;
    int         total_checks;

    srs_if bus ();
    srs_dev #(.STRAP_CYC(1)) i_srs_dev (.i_ref_clk(clk), .i_srst(srst), .bus(bus),
        .i_addr_sel(sel), .i_rd_data(mem[rd_addr]), .o_rd_addr(rd_addr),
        .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_own_addr(own), .o_busy(d_busy));
    // shortened quarter period keeps a write near 1160 cycles and a read near 1560
    srs_host #(.QTR_CYC(10)) i_srs_host (.i_ref_clk(clk), .i_srst(srst), .bus(bus),
        .i_go(go), .i_rw(rw), .i_dev_addr(dev), .i_reg_addr(rg), .i_wr_data(wd),
        .o_busy(h_busy), .o_done(done), .o_ack_err(ack_err), .o_rd_data(h_rd));
    srs_properties i_srs_properties (.i_ref_clk(clk), .i_srst(srst),
        .host_scl_o(bus.host_scl_o), .host_scl_oe_n(bus.host_scl_oe_n),
        .host_sda_o(bus.host_sda_o), .host_sda_oe_n(bus.host_sda_oe_n),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
        .scl(bus.scl), .sda(bus.sda));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // register file behind the slave, plus a wire watcher for the first byte
    always @(posedge clk) begin
        scl_q <= bus.scl;
        sda_q <= bus.sda;
        if (wr_stb) begin
            stb_n <= stb_n + 1;
            mem[wr_addr] <= wr_data;
        end
        if (!bus.dev_sda_oe_n)
            drove <= 1'b1;
        if (d_busy)
            busy_seen <= 1'b1;
        if (scl_q && bus.scl && sda_q && !bus.sda)
            bit_n <= 0;
        else if (bus.scl && !scl_q) begin
            bit_n <= bit_n + 1;
            if (bit_n < 8)
                shf <= {shf[6:0], bus.sda};
            if (bit_n == 8)
                first_byte <= shf;
        end
    end

    task automatic report_and_stop;
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic s);
        sel = s;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] g,
                        input logic [7:0] d);
        int n;
        go = 1'b1;
        rw = r;
        dev = a;
        rg = g;
        wd = d;
        @(posedge clk);
        #1 go = 1'b0;
        chk({7'h00, h_busy}, 8'h01);
        n = 0;
        while (done !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        chk({7'h00, done}, 8'h01);
        chk({6'h00, h_busy, d_busy}, 8'h00);
    endtask

    task automatic t_write_read;
        int s0;
        s0 = stb_n;
        busy_seen = 1'b0;
        xfer(1'b0, 7'h55, 8'ha5, 8'h3c);
        chk({7'h00, busy_seen}, 8'h01);
        chk({7'h00, ack_err}, 8'h00);
        chk(first_byte, 8'haa);
        chk(wr_addr, 8'ha5);
        chk(wr_data, 8'h3c);
        // back to back, boundary register and data values
        xfer(1'b0, 7'h55, 8'h00, 8'hff);
        chk(wr_data, 8'hff);
        chk(8'(stb_n - s0), 8'h02);
        xfer(1'b1, 7'h55, 8'ha5, 8'h00);
        chk({7'h00, ack_err}, 8'h00);
        chk(first_byte, 8'hab);
        chk(h_rd, 8'h3c);
        xfer(1'b1, 7'h55, 8'h00, 8'h00);
        chk(h_rd, 8'hff);
        chk(8'(stb_n - s0), 8'h02);
    endtask

    task automatic t_foreign;
        int s0;
        s0 = stb_n;
        drove = 1'b0;
        xfer(1'b0, 7'h33, 8'h10, 8'h77);
        chk({7'h00, ack_err}, 8'h01);
        chk({7'h00, drove}, 8'h00);
        chk(8'(stb_n - s0), 8'h00);
        xfer(1'b1, 7'h55, 8'h10, 8'h00);
        chk(h_rd, 8'h4a);
    endtask

    task automatic t_strap;
        sel = 1'b1;
        xfer(1'b0, 7'h55, 8'h20, 8'h81);
        chk({7'h00, ack_err}, 8'h00);
        chk({1'b0, own}, 8'h55);
        do_reset(1'b1);
        chk({1'b0, own}, 8'h33);
        xfer(1'b0, 7'h33, 8'h21, 8'h18);
        chk({7'h00, ack_err}, 8'h00);
        chk(wr_data, 8'h18);
        xfer(1'b0, 7'h55, 8'h22, 8'h00);
        chk({7'h00, ack_err}, 8'h01);
    endtask

    initial begin
        srst = 1'b1;
        sel = 1'b0;
        go = 1'b0;
        rw = 1'b0;
        dev = 7'h00;
        rg = 8'h00;
        wd = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
        do_reset(1'b0);
        t_write_read;
        t_foreign;
        t_strap;
        report_and_stop;
    end
endmodule // tb_serial_register_slave
